// File: src/edc_pkg.sv
package edc_pkg;
	// Core clock rate
	localparam int unsigned CLK_HZ = 10_000_000;
	// Turn-off delay, typical figure
	localparam int unsigned OFF_DELAY_MS = 10;
	localparam int unsigned OFF_DELAY_CYC = OFF_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned OFF_CNT_W = 20;
	// Embedded engine period in oscillator cycles
	localparam int unsigned ENG_PERIOD = 511;
	localparam int unsigned ENG_CNT_W = 9;
	// Level code: enable_dim_input fraction in 1/1024 steps
	localparam int unsigned LVL_W = 10;
	localparam logic [LVL_W-1:0] LVL_OFF = 10'h0CD; // about 0.2
	localparam logic [LVL_W-1:0] LVL_DC0 = 10'h148; // 0.32
	localparam logic [LVL_W-1:0] LVL_DC100 = 10'h23D; // 0.56
	localparam logic [LVL_W-1:0] LVL_ON = 10'h266; // about 0.6
	localparam logic [LVL_W-1:0] LVL_SPAN = 10'h0F5; // 0.24
	localparam logic [ENG_CNT_W-1:0] ENG_LAST = 9'h1FE;

	typedef enum logic [2:0] {
		EDC_OFF = 3'b001,
		EDC_DIGITAL = 3'b010,
		EDC_ENGINE = 3'b100
	} edc_mode_t;

	typedef struct packed {
		logic switch_en;
		logic dim_en;
	} edc_drive_t;
endpackage

// File: src/edc_engine.sv
`timescale 1ns/1ns
module edc_engine (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic osc_tick,
	input wire logic [edc_pkg::ENG_CNT_W-1:0] duty,
	output logic pwm
);
	import edc_pkg::*;

	logic [ENG_CNT_W-1:0] phase;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase <= '0;
		end else if (!run) begin
			phase <= '0;
		end else if (osc_tick) begin
			phase <= (phase == ENG_LAST) ? '0 : phase + 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pwm <= 1'b0;
		end else begin
			pwm <= run && (phase < duty);
		end
	end
endmodule

// File: src/edc_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Level below off threshold reads as low
// - Level above on threshold: digital PWM
// - Mid window runs embedded PWM engine
// - Power off only after full low delay
// - Digital mode: input gates drivers directly
// - Engine duty from level minus 0.32 over 0.24
// - Engine period is 511 oscillator cycles
// - Engine output gates drivers like digital PWM
// - Undriven input defaults to shutdown
module edc_top #(
	parameter int unsigned OFF_CYCLES = edc_pkg::OFF_DELAY_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [edc_pkg::LVL_W-1:0] enable_dim_input,
	input wire logic dim_freq_capacitor,
	input wire logic internal_supply,
	output logic powered,
	output edc_pkg::edc_mode_t mode,
	output edc_pkg::edc_drive_t drive
);
	import edc_pkg::*;

	function automatic logic [ENG_CNT_W-1:0] duty_of(
		input logic [LVL_W-1:0] lvl
	);
		logic [LVL_W+ENG_CNT_W-1:0] prod;
		prod = '0;
		if (lvl <= LVL_DC0) begin
			duty_of = '0;
		end else if (lvl >= LVL_DC100) begin
			duty_of = ENG_CNT_W'(ENG_PERIOD);
		end else begin
			prod = (LVL_W+ENG_CNT_W)'(lvl - LVL_DC0) *
				(LVL_W+ENG_CNT_W)'(ENG_PERIOD);
			duty_of = ENG_CNT_W'(prod / (LVL_W+ENG_CNT_W)'(LVL_SPAN));
		end
	endfunction

	// Three-stage pin synchronisers; word only used when stages agree
	logic [LVL_W-1:0] lvl_s1, lvl_s2, lvl_s3, lvl;
	logic [2:0] osc_s, sup_s;
	logic osc_prev, osc_tick, sup_ok;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lvl_s1 <= '0;
			lvl_s2 <= '0;
			lvl_s3 <= '0;
			osc_s <= '0;
			sup_s <= '0;
		end else begin
			lvl_s1 <= enable_dim_input;
			lvl_s2 <= lvl_s1;
			lvl_s3 <= lvl_s2;
			osc_s <= {osc_s[1:0], dim_freq_capacitor};
			sup_s <= {sup_s[1:0], internal_supply};
		end
	end

	// reset and undriven level read as low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lvl <= '0;
			osc_prev <= 1'b0;
			sup_ok <= 1'b0;
		end else begin
			if (lvl_s2 == lvl_s3) begin
				lvl <= lvl_s3;
			end
			if (osc_s[1] == osc_s[2]) begin
				osc_prev <= osc_s[2];
			end
			if (sup_s[1] == sup_s[2]) begin
				sup_ok <= sup_s[2];
			end
		end
	end

	assign osc_tick = (osc_s[1] == osc_s[2]) && osc_s[2] && !osc_prev;

	logic is_low, is_high;
	assign is_low = lvl < LVL_OFF;
	assign is_high = lvl > LVL_ON;

	logic [OFF_CNT_W-1:0] low_cnt;
	logic low_expired;
	assign low_expired = low_cnt >= OFF_CNT_W'(OFF_CYCLES - 1);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			low_cnt <= '0;
		end else if (!is_low || !powered) begin
			low_cnt <= '0;
		end else if (!low_expired) begin
			low_cnt <= low_cnt + 1'b1;
		end
	end

	// wake only on high with supply up
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			powered <= 1'b0;
		end else if (!powered) begin
			powered <= is_high && sup_ok;
		end else if (is_low && low_expired) begin
			powered <= 1'b0;
		end
	end

	edc_mode_t next_mode;
	always_comb begin
		next_mode = mode;
		case (mode)
			EDC_OFF: begin
				if (is_high && sup_ok) begin
					next_mode = EDC_DIGITAL;
				end
			end
			EDC_DIGITAL, EDC_ENGINE: begin
				if (is_low && low_expired) begin
					next_mode = EDC_OFF;
				end else if (!is_low && !is_high) begin
					next_mode = EDC_ENGINE;
				end else if (is_high) begin
					next_mode = EDC_DIGITAL;
				end
			end
			default: begin
				next_mode = EDC_OFF;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode <= EDC_OFF;
		end else begin
			mode <= next_mode;
		end
	end

	logic [ENG_CNT_W-1:0] duty;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			duty <= '0;
		end else begin
			duty <= duty_of(lvl);
		end
	end

	logic eng_pwm;
	edc_engine u_engine (
		.core_clk(core_clk),
		.rst(rst),
		.run(mode == EDC_ENGINE),
		.osc_tick(osc_tick),
		.duty(duty),
		.pwm(eng_pwm)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			drive <= '0;
		end else begin
			case (mode)
				EDC_DIGITAL: begin
					drive.switch_en <= is_high;
					drive.dim_en <= is_high;
				end
				EDC_ENGINE: begin
					drive.switch_en <= eng_pwm;
					drive.dim_en <= eng_pwm;
				end
				default: begin
					drive <= '0;
				end
			endcase
		end
	end
endmodule

// File: dv/edc_source.sv
`timescale 1ns/1ns
module edc_source (
	input wire logic core_clk,
	input wire logic drv,
	input wire logic [9:0] req,
	output logic [9:0] pin,
	output logic osc,
	output logic sup
);
	int n = 0;
	logic half = 1'b0;
	initial osc = 1'b0;
	// Oscillator toggles every second clock so synchroniser stages agree
	always @(posedge core_clk) begin
		half <= #1 ~half;
		if (half) begin
			osc <= #1 ~osc;
		end
		if (drv && n < 60) begin
			n <= #1 n + 1;
		end
	end
	assign sup = n >= 40;
	assign pin = !drv ? 10'h000 : (n < 60 ? 10'h3FF : req);
endmodule

// File: dv/edc_properties.sv
`timescale 1ns/1ns
module edc_checker #(
	parameter int unsigned OFF_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [edc_pkg::LVL_W-1:0] enable_dim_input,
	input wire logic dim_freq_capacitor,
	input wire logic internal_supply,
	input wire logic powered,
	input wire edc_pkg::edc_mode_t mode,
	input wire edc_pkg::edc_drive_t drive
);
	import edc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire lo = enable_dim_input < LVL_OFF;
	wire hi = enable_dim_input > LVL_ON;
	wire eng = mode == EDC_ENGINE && enable_dim_input == LVL_DC100;
	property p_q; mode == EDC_OFF |-> drive == 2'b00; endproperty
	a_q: assert property (p_q) else $error("off drive");
	property p_w; (hi && internal_supply)[*8] |-> powered; endproperty
	a_w: assert property (p_w) else $error("no wake");
	property p_e; (powered && !lo && !hi)[*8] |-> mode == EDC_ENGINE; endproperty
	a_e: assert property (p_e) else $error("no engine");
	property p_h; $fell(powered) |-> $past(lo, 6) && $past(lo, 45); endproperty
	a_h: assert property (p_h) else $error("early off");
	property p_l; (mode == EDC_DIGITAL && lo)[*8] |-> drive == 2'b00; endproperty
	a_l: assert property (p_l) else $error("low drive");
	property p_d; (mode == EDC_DIGITAL && hi)[*8] |-> drive == 2'b11; endproperty
	a_d: assert property (p_d) else $error("high drive");
	property p_f; eng[*8] ##1 eng[*4] |-> drive == 2'b11; endproperty
	a_f: assert property (p_f) else $error("full duty");
	property p_s; (!powered && !hi)[*8] |=> !powered; endproperty
	a_s: assert property (p_s) else $error("woke");
endmodule
bind edc_top edc_checker #(.OFF_CYCLES(OFF_CYCLES)) edc_checker_inst (.core_clk,
	.rst, .enable_dim_input, .dim_freq_capacitor, .internal_supply,
	.powered, .mode, .drive);

// File: dv/edc_top_test.sv
`timescale 1ns/1ns
module edc_top_test;
	import edc_pkg::*;
	localparam int unsigned OFF = 50;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic drv = 1'b0;
	logic [9:0] req = 10'h000;
	logic [9:0] pin;
	logic osc, sup, powered;
	edc_mode_t mode;
	edc_drive_t drive;
	int fails = 0;
	int num_checks = 0;
	always #50 core_clk = ~core_clk;
	edc_source edc_source_inst (.core_clk, .drv, .req, .pin, .osc, .sup);
	edc_top #(.OFF_CYCLES(OFF)) edc_top_inst (.core_clk, .rst,
		.enable_dim_input(pin), .dim_freq_capacitor(osc),
		.internal_supply(sup), .powered, .mode, .drive);
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [31:0] v, e);
		num_checks++;
		if (v !== e) begin
			fails++;
			$display("wrong value %s exp %h seen %h", s, e, v);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_wake;
		drv = 1'b1;
		req = LVL_DC100;
		cyc(70);
		chk("powered", 32'(powered), 1);
		cyc(30);
		chk("mode", 32'(mode), 32'(EDC_ENGINE));
	endtask
	task automatic t_digital;
		for (int i = 0; i < 3; i++) begin
			req = 10'h000;
			cyc(30);
			chk("low", 32'(drive), 0);
			chk("powered", 32'(powered), 1);
			req = 10'h3FF;
			cyc(10);
			chk("high", 32'(drive), 3);
		end
	endtask
	task automatic t_engine;
		logic [9:0] l[3] = '{LVL_DC0, 10'h1C2, LVL_DC100};
		int h;
		foreach (l[i]) begin
			req = l[i];
			cyc(20);
			h = 0;
			repeat (2044) begin
				cyc(1);
				if (drive === 2'b11) h++;
			end
			chk("duty", h, (l[i] - LVL_DC0) * ENG_PERIOD / LVL_SPAN * 4);
		end
	endtask
	task automatic t_off;
		req = 10'h0CC;
		cyc(OFF - 10);
		chk("early", 32'(powered), 1);
		cyc(40);
		chk("off", 32'(mode), 32'(EDC_OFF));
		req = LVL_DC100;
		cyc(30);
		chk("asleep", 32'(powered), 0);
	endtask
	initial begin
		cyc(20);
		rst = 1'b0;
		t_wake();
		t_digital();
		t_engine();
		t_off();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		complete_run();
	end
endmodule
